// [logic/dbc_pkg.sv]
// Package with register map, field layout and timing constants of the dead-band and chopper stage.
`default_nettype none
package dbc_pkg;
  // Register bus geometry.
  localparam int          ADDR_W       = 5;
  localparam int          DATA_W       = 16;
  // Register offsets (byte addresses, one word each).
  localparam logic [4:0]  OFS_DB_CTRL  = 5'h00;
  localparam logic [4:0]  OFS_RISE_DLY = 5'h04;
  localparam logic [4:0]  OFS_FALL_DLY = 5'h08;
  localparam logic [4:0]  OFS_CHOP     = 5'h0C;
  localparam logic [4:0]  OFS_STATUS   = 5'h10;
  // deadband_control fields.
  localparam int          HALF_BIT     = 15;
  localparam int          IN_SEL_LSB   = 4;
  localparam int          POL_LSB      = 2;
  localparam int          MODE_LSB     = 0;
  // Delay count fields.
  localparam int          DELAY_W      = 10;
  localparam int          DELAY_LSB    = 0;
  // chopper_control fields.
  localparam int          DUTY_LSB     = 8;
  localparam int          FREQ_LSB     = 5;
  localparam int          WIDTH_LSB    = 1;
  localparam int          CHOP_EN_BIT  = 0;
  // Writable bits of each register; the rest are reserved and read as zero.
  localparam logic [15:0] MASK_DB_CTRL = 16'h803F;
  localparam logic [15:0] MASK_DELAY   = 16'h03FF;
  localparam logic [15:0] MASK_CHOP    = 16'h07FF;
  // Reset values.
  localparam logic [15:0] RST_DB_CTRL  = 16'h0000;
  localparam logic [15:0] RST_RISE_DLY = 16'h0000;
  localparam logic [15:0] RST_FALL_DLY = 16'h0000;
  localparam logic [15:0] RST_CHOP     = 16'h0000;
  // Carrier timing: base carrier is system clock / 8, duty in eighths.
  localparam logic [2:0]  CARRIER_LAST = 3'h7;
  localparam logic [2:0]  DUTY_MAX     = 3'h6;
  localparam logic [2:0]  SHOT_LSBS    = 3'h7;
  // Chopper per-channel sequence.
  typedef enum logic [1:0] {
    DBC_CHOP_IDLE,
    DBC_CHOP_SHOT,
    DBC_CHOP_CARRY
  } dbc_chop_state_t;
endpackage
`default_nettype wire

// [logic/dbc_top.sv]
// Dead-band generator followed by a PWM chopper, with its register port.
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module dbc_top (
  // Clock and reset.
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset,
  // Register port.
  input  wire logic [4:0]  i_addr,
  input  wire logic [15:0] i_wr_data,
  input  wire logic        i_wr_stb,
  input  wire logic        i_rd_stb,
  output var  logic [15:0] o_rd_data,
  // Time-base ticks: one per time-base clock, and one at its half period.
  input  wire logic        i_tb_tick,
  input  wire logic        i_tb_mid_tick,
  // Action-qualifier waveforms.
  input  wire logic        i_pwm_a,
  input  wire logic        i_pwm_b,
  // Shaped outputs.
  output var  logic        o_out_a,
  output var  logic        o_out_b
);

  function automatic logic [6:0] shot_load(input logic [3:0] width);
    shot_load = {width, dbc_pkg::SHOT_LSBS};
  endfunction

  function automatic logic [15:0] reg_write(input logic [15:0] data, input logic [15:0] mask);
    reg_write = data & mask;
  endfunction

  logic [15:0]                    db_ctrl_q;
  logic [15:0]                    rise_reg_q;
  logic [15:0]                    fall_reg_q;
  logic [15:0]                    chop_reg_q;
  logic [15:0]                    rd_data_q;
  logic [9:0]                     rise_cnt_q;
  logic [9:0]                     rise_cnt_d;
  logic [9:0]                     fall_cnt_q;
  logic [9:0]                     fall_cnt_d;
  logic [2:0]                     sub_q;
  logic [2:0]                     sub_d;
  logic [2:0]                     step_q;
  logic [2:0]                     step_d;
  dbc_pkg::dbc_chop_state_t       chop_st_q [2];
  dbc_pkg::dbc_chop_state_t       chop_st_d [2];
  logic [6:0]                     chop_cnt_q [2];
  logic [6:0]                     chop_cnt_d [2];
  logic [1:0]                     out_q;
  logic [1:0]                     out_d;

  // Register decode.
  wire        sel_db_ctrl = (i_addr == dbc_pkg::OFS_DB_CTRL);
  wire        sel_rise    = (i_addr == dbc_pkg::OFS_RISE_DLY);
  wire        sel_fall    = (i_addr == dbc_pkg::OFS_FALL_DLY);
  wire        sel_chop    = (i_addr == dbc_pkg::OFS_CHOP);
  wire        sel_status  = (i_addr == dbc_pkg::OFS_STATUS);

  // Configuration fields.
  wire        half_w      = db_ctrl_q[dbc_pkg::HALF_BIT];
  wire [1:0]  in_sel_w    = db_ctrl_q[dbc_pkg::IN_SEL_LSB +: 2];
  wire [1:0]  pol_w       = db_ctrl_q[dbc_pkg::POL_LSB +: 2];
  wire [1:0]  mode_w      = db_ctrl_q[dbc_pkg::MODE_LSB +: 2];
  wire [9:0]  red_w       = rise_reg_q[dbc_pkg::DELAY_LSB +: dbc_pkg::DELAY_W];
  wire [9:0]  fed_w       = fall_reg_q[dbc_pkg::DELAY_LSB +: dbc_pkg::DELAY_W];
  wire [2:0]  duty_w      = chop_reg_q[dbc_pkg::DUTY_LSB +: 3];
  wire [2:0]  freq_w      = chop_reg_q[dbc_pkg::FREQ_LSB +: 3];
  wire [3:0]  width_w     = chop_reg_q[dbc_pkg::WIDTH_LSB +: 4];
  wire        chop_en_w   = chop_reg_q[dbc_pkg::CHOP_EN_BIT];

  // Dead-band delay path.
  wire        rise_src    = in_sel_w[0] ? i_pwm_b : i_pwm_a;
  wire        fall_src    = in_sel_w[1] ? i_pwm_b : i_pwm_a;
  wire        dly_tick    = i_tb_tick | (half_w & i_tb_mid_tick);
  wire        rise_dly    = rise_src & (rise_cnt_q == red_w);
  wire        fall_dly    = fall_src | (fall_cnt_q != fed_w);
  wire        db_a        = mode_w[1] ? (rise_dly ^ pol_w[0]) : i_pwm_a;
  wire        db_b        = mode_w[0] ? (fall_dly ^ pol_w[1]) : i_pwm_b;
  wire [1:0]  db_w        = {db_b, db_a};

  // Carrier: sub counts system clocks per eighth, step counts eighths.
  wire [2:0]  duty_eff    = (duty_w > dbc_pkg::DUTY_MAX) ? dbc_pkg::DUTY_MAX : duty_w;
  wire        sub_wrap    = (sub_q >= freq_w);
  wire        carrier_w   = (step_q <= duty_eff);
  wire [6:0]  shot_len_w  = shot_load(width_w);

  // Read data of the addressed register.
  wire [15:0] rd_mux      = sel_db_ctrl ? db_ctrl_q :
                            sel_rise    ? rise_reg_q :
                            sel_fall    ? fall_reg_q :
                            sel_chop    ? chop_reg_q :
                            sel_status  ? {13'h0000, carrier_w, out_q} : 16'h0000;

  always_comb begin
    rise_cnt_d = rise_cnt_q;
    fall_cnt_d = fall_cnt_q;
    if (!rise_src) begin
      rise_cnt_d = 10'h000;
    end else if (dly_tick && (rise_cnt_q < red_w)) begin
      rise_cnt_d = rise_cnt_q + 10'h001;
    end
    if (fall_src) begin
      fall_cnt_d = 10'h000;
    end else if (dly_tick && (fall_cnt_q < fed_w)) begin
      fall_cnt_d = fall_cnt_q + 10'h001;
    end
  end

  always_comb begin
    sub_d  = sub_wrap ? 3'h0 : sub_q + 3'h1;
    step_d = sub_wrap ? step_q + 3'h1 : step_q;
  end

  // Per-channel first pulse then carrier gating; the rising cycle counts as the first shot clock.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      chop_st_d[i]  = chop_st_q[i];
      chop_cnt_d[i] = chop_cnt_q[i];
      out_d[i]      = db_w[i];
      case (chop_st_q[i])
        dbc_pkg::DBC_CHOP_IDLE: begin
          if (db_w[i]) begin
            chop_st_d[i]  = dbc_pkg::DBC_CHOP_SHOT;
            chop_cnt_d[i] = shot_len_w;
          end
        end
        dbc_pkg::DBC_CHOP_SHOT: begin
          if (!db_w[i]) begin
            chop_st_d[i] = dbc_pkg::DBC_CHOP_IDLE;
          end else if (chop_cnt_q[i] == 7'h01) begin
            chop_st_d[i] = dbc_pkg::DBC_CHOP_CARRY;
          end else begin
            chop_cnt_d[i] = chop_cnt_q[i] - 7'h01;
          end
        end
        dbc_pkg::DBC_CHOP_CARRY: begin
          if (!db_w[i]) begin
            chop_st_d[i] = dbc_pkg::DBC_CHOP_IDLE;
          end
          if (chop_en_w) begin
            out_d[i] = db_w[i] & carrier_w;
          end
        end
        default: begin
          chop_st_d[i] = dbc_pkg::DBC_CHOP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      db_ctrl_q  <= dbc_pkg::RST_DB_CTRL;
      rise_reg_q <= dbc_pkg::RST_RISE_DLY;
      fall_reg_q <= dbc_pkg::RST_FALL_DLY;
      chop_reg_q <= dbc_pkg::RST_CHOP;
    end else if (i_wr_stb) begin
      if (sel_db_ctrl) begin
        db_ctrl_q <= reg_write(i_wr_data, dbc_pkg::MASK_DB_CTRL);
      end
      if (sel_rise) begin
        rise_reg_q <= reg_write(i_wr_data, dbc_pkg::MASK_DELAY);
      end
      if (sel_fall) begin
        fall_reg_q <= reg_write(i_wr_data, dbc_pkg::MASK_DELAY);
      end
      if (sel_chop) begin
        chop_reg_q <= reg_write(i_wr_data, dbc_pkg::MASK_CHOP);
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      rd_data_q <= 16'h0000;
    end else begin
      rd_data_q <= i_rd_stb ? rd_mux : 16'h0000;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      rise_cnt_q <= 10'h000;
      fall_cnt_q <= 10'h000;
      sub_q      <= 3'h0;
      step_q     <= 3'h0;
      out_q      <= 2'h0;
    end else begin
      rise_cnt_q <= rise_cnt_d;
      fall_cnt_q <= fall_cnt_d;
      sub_q      <= sub_d;
      step_q     <= step_d;
      out_q      <= out_d;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    for (int i = 0; i < 2; i++) begin
      if (i_reset) begin
        chop_st_q[i]  <= dbc_pkg::DBC_CHOP_IDLE;
        chop_cnt_q[i] <= 7'h00;
      end else begin
        chop_st_q[i]  <= chop_st_d[i];
        chop_cnt_q[i] <= chop_cnt_d[i];
      end
    end
  end

  assign o_rd_data = rd_data_q;
  assign o_out_a   = out_q[0];
  assign o_out_b   = out_q[1];

  default clocking cb_sys @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);

  sequence s_rise_counting;
    rise_src && dly_tick && (rise_cnt_q < red_w);
  endsequence

  sequence s_shot_start;
    chop_en_w && db_a && (chop_st_q[0] == dbc_pkg::DBC_CHOP_IDLE);
  endsequence

  sequence s_carrier_gap;
    chop_en_w && (chop_st_q[0] == dbc_pkg::DBC_CHOP_CARRY) && !carrier_w;
  endsequence

  sequence s_fall_counting;
    !fall_src && dly_tick && (fall_cnt_q < fed_w);
  endsequence

  sequence s_shot_last;
    (chop_st_q[0] == dbc_pkg::DBC_CHOP_SHOT) && db_a && (chop_cnt_q[0] == 7'h01);
  endsequence

  a_bypass_path_a: assert property ((mode_w == 2'h0) && !chop_en_w |=> (o_out_a == $past(i_pwm_a)))
    else $error("Bypass mode did not pass path A.");

  a_bypass_path_b: assert property ((mode_w == 2'h0) && !chop_en_w |=> (o_out_b == $past(i_pwm_b)))
    else $error("Bypass mode did not pass path B.");

  a_polarity_both: assert property ((mode_w == 2'h3) && (pol_w == 2'h3) && !rise_src && !fall_src
                                    && (fall_cnt_q == fed_w) |-> (db_a && db_b))
    else $error("Inverted polarity did not raise both idle outputs.");

  a_rise_hold_low: assert property (mode_w[1] && !pol_w[0] && rise_src && (rise_cnt_q != red_w) |-> !db_a)
    else $error("Rising-delayed output rose before its count.");

  a_fall_src_high: assert property ((mode_w == 2'h1) && !pol_w[1] && fall_src |-> db_b)
    else $error("Falling-delayed output not high with its source.");

  a_rise_count_step: assert property (s_rise_counting |=> (rise_cnt_q == $past(rise_cnt_q) + 10'h001))
    else $error("Rising delay counter missed a tick.");

  a_carrier_wrap: assert property (sub_wrap && (step_q == dbc_pkg::CARRIER_LAST) |=> (step_q == 3'h0))
    else $error("Carrier step did not wrap after eighth step.");

  a_shot_width_load: assert property (s_shot_start |=> (chop_cnt_q[0] == $past(shot_len_w)))
    else $error("First pulse length loaded wrongly.");

  a_chop_gate_low: assert property (s_carrier_gap |=> !o_out_a)
    else $error("Chopped output high while carrier low.");

  // Polarity and path selection of the dead-band stage.
  a_pol_a_only: assert property ((mode_w == 2'h2) && (pol_w == 2'h1) && !rise_src |-> db_a)
    else $error("Path A not inverted by polarity code.");

  a_pol_b_only: assert property ((mode_w == 2'h1) && (pol_w == 2'h2) && fall_src |-> !db_b)
    else $error("Path B not inverted by polarity code.");

  a_straight_a: assert property ((mode_w == 2'h1) |-> (db_a == i_pwm_a))
    else $error("Path A not passed straight in falling-only mode.");

  a_straight_b: assert property ((mode_w == 2'h2) |-> (db_b == i_pwm_b))
    else $error("Path B not passed straight in rising-only mode.");

  a_both_from_b: assert property ((mode_w == 2'h3) && (pol_w == 2'h0) && (in_sel_w == 2'h3)
                                  && (rise_cnt_q == red_w) |-> (db_a == i_pwm_b))
    else $error("Rising delay did not take path B as source.");

  a_rise_src_pick: assert property ((in_sel_w[0] == 1'b0) |-> (rise_src == i_pwm_a))
    else $error("Rising delay source not path A.");

  a_fall_src_pick: assert property ((in_sel_w[1] == 1'b1) |-> (fall_src == i_pwm_b))
    else $error("Falling delay source not path B.");

  // Delay counters and delayed edges.
  a_rise_with_src: assert property (mode_w[1] && !pol_w[0] && !rise_src |-> !db_a)
    else $error("Rising-delayed output did not fall with its source.");

  a_rise_done_high: assert property (mode_w[1] && !pol_w[0] && rise_src && (rise_cnt_q == red_w) |-> db_a)
    else $error("Rising-delayed output low after its count.");

  a_fall_hold_high: assert property (mode_w[0] && !pol_w[1] && (fall_cnt_q != fed_w) |-> db_b)
    else $error("Falling-delayed output dropped before its count.");

  a_fall_count_step: assert property (s_fall_counting |=> (fall_cnt_q == $past(fall_cnt_q) + 10'h001))
    else $error("Falling delay counter missed a tick.");

  a_rise_count_hold: assert property (rise_src && !dly_tick |=> (rise_cnt_q == $past(rise_cnt_q)))
    else $error("Rising delay counter moved without a tick.");

  a_full_rate_tick: assert property (!half_w |-> (dly_tick == i_tb_tick))
    else $error("Delay counters ticked at the wrong rate.");

  a_rise_reserved: assert property ((rise_reg_q & ~dbc_pkg::MASK_DELAY) == 16'h0000)
    else $error("Reserved bits of the rising delay register set.");

  a_fall_reserved: assert property ((fall_reg_q & ~dbc_pkg::MASK_DELAY) == 16'h0000)
    else $error("Reserved bits of the falling delay register set.");

  // Carrier, first pulse and chopping.
  a_duty_reserved: assert property ((duty_w == 3'h7) |-> (duty_eff == dbc_pkg::DUTY_MAX))
    else $error("Reserved duty code not limited.");

  a_step_hold: assert property (!sub_wrap |=> (step_q == $past(step_q)))
    else $error("Carrier step moved before the divider wrapped.");

  a_sub_restart: assert property (sub_wrap |=> (sub_q == 3'h0))
    else $error("Carrier divider did not restart.");

  a_shot_high: assert property ((chop_st_q[0] == dbc_pkg::DBC_CHOP_SHOT) && db_a |=> o_out_a)
    else $error("First pulse dropped early.");

  a_shot_to_carry: assert property (s_shot_last |=> (chop_st_q[0] == dbc_pkg::DBC_CHOP_CARRY))
    else $error("First pulse did not hand over to the carrier.");

  a_chop_off_a: assert property (!chop_en_w |=> (o_out_a == $past(db_a)))
    else $error("Disabled chopper altered path A.");

  a_chop_off_b: assert property (!chop_en_w |=> (o_out_b == $past(db_b)))
    else $error("Disabled chopper altered path B.");

  a_chop_gate_high: assert property (chop_en_w && (chop_st_q[0] == dbc_pkg::DBC_CHOP_CARRY)
                                     && carrier_w && db_a |=> o_out_a)
    else $error("Chopped output low while carrier high.");

endmodule
`default_nettype wire

// [test/dbc_aq_model.sv]
// Stand-in for the action-qualifier: drives both paths and the time-base ticks.
`timescale 1ns/10ps
`default_nettype none
module dbc_aq_model (
  // Clock and reset.
  input  wire logic i_clk_sys,
  input  wire logic i_reset,
  // Levels commanded by the bench.
  input  wire logic i_lvl_a,
  input  wire logic i_lvl_b,
  // Waveforms and time-base ticks, eight system clocks per tick.
  output var  logic o_pwm_a,
  output var  logic o_pwm_b,
  output var  logic o_tb_tick,
  output var  logic o_tb_mid_tick
);
  logic [2:0] phase_q;
  always_ff @(posedge i_clk_sys) begin
    phase_q       <= i_reset ? 3'h0 : phase_q + 3'h1;
    o_pwm_a       <= i_lvl_a;
    o_pwm_b       <= i_lvl_b;
    o_tb_tick     <= phase_q == 3'h7;
    o_tb_mid_tick <= phase_q == 3'h3;
  end
endmodule
`default_nettype wire

// [test/dbc_top_bench.sv]
// Self-checking bench of the dead-band and chopper stage.
`timescale 1ns/10ps
`default_nettype none
module dbc_top_bench;
  logic        clk   = 1'b0;
  logic        rst   = 1'b1;
  logic [4:0]  addr  = 5'h00;
  logic [15:0] wdata = 16'h0000;
  logic        wr    = 1'b0;
  logic        rd    = 1'b0;
  logic        lvl_a = 1'b0;
  logic        lvl_b = 1'b0;
  logic [15:0] rdata;
  logic        pwm_a, pwm_b, tick, mid, out_a, out_b;
  int          fails        = 0;
  int          total_checks = 0;
  int          cycles       = 0;
  always #20 clk = ~clk;
  dbc_aq_model u_aq (.i_clk_sys(clk), .i_reset(rst), .i_lvl_a(lvl_a), .i_lvl_b(lvl_b),
    .o_pwm_a(pwm_a), .o_pwm_b(pwm_b), .o_tb_tick(tick), .o_tb_mid_tick(mid));
  dbc_top u_dut (.i_clk_sys(clk), .i_reset(rst), .i_addr(addr), .i_wr_data(wdata), .i_wr_stb(wr),
    .i_rd_stb(rd), .o_rd_data(rdata), .i_tb_tick(tick), .i_tb_mid_tick(mid), .i_pwm_a(pwm_a),
    .i_pwm_b(pwm_b), .o_out_a(out_a), .o_out_b(out_b));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fails = fails + 1;
      end_of_test();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_in(input int got, input int lo, input int hi);
    total_checks++;
    if (got < lo || got > hi) begin
      fails++;
      $display("mismatch at %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Counts edges until out_a or out_b reaches the wanted level, at most 200.
  task automatic wait_out(input logic sel_b, input logic lvl, output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while ((sel_b ? out_b : out_a) !== lvl && n < 200);
  endtask
  task automatic test_regs();
    logic [15:0] d;
    logic [4:0]  ofs [4] = '{dbc_pkg::OFS_DB_CTRL, dbc_pkg::OFS_RISE_DLY, dbc_pkg::OFS_FALL_DLY, dbc_pkg::OFS_CHOP};
    logic [15:0] msk [4] = '{dbc_pkg::MASK_DB_CTRL, dbc_pkg::MASK_DELAY, dbc_pkg::MASK_DELAY, dbc_pkg::MASK_CHOP};
    for (int i = 0; i < 4; i++) begin
      rd_reg(ofs[i], d);
      check(d, 16'h0000);
      wr_reg(ofs[i], 16'hFFFF);
      rd_reg(ofs[i], d);
      check(d, msk[i]);
      wr_reg(ofs[i], 16'h0000);
    end
    wr_reg(5'h14, 16'hFFFF);
    rd_reg(5'h14, d);
    check(d, 16'h0000);
    $display("registers done");
  endtask
  task automatic test_bypass();
    logic [15:0] d;
    wr_reg(dbc_pkg::OFS_DB_CTRL, 16'h003C);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      lvl_a <= i[0];
      lvl_b <= i[1];
      repeat (3) @(posedge clk);
      #1 check({out_a, out_b}, {i[0], i[1]});
      rd_reg(dbc_pkg::OFS_STATUS, d);
      check(d & 16'hFFFB, {14'h0000, i[1], i[0]});
    end
    $display("bypass done");
  endtask
  task automatic test_modes();
    logic [1:0] m, s, p;
    logic       ea, eb;
    lvl_a <= 1'b0;
    lvl_b <= 1'b1;
    for (int k = 16; k < 64; k++) begin
      {m, s, p} = 6'(k);
      wr_reg(dbc_pkg::OFS_DB_CTRL, {10'h000, s, p, m});
      repeat (4) @(posedge clk);
      ea = m[1] ? (s[0] ? 1'b1 : 1'b0) ^ p[0] : 1'b0;
      eb = m[0] ? (s[1] ? 1'b1 : 1'b0) ^ p[1] : 1'b1;
      #1 check({out_a, out_b}, {ea, eb});
    end
    $display("modes done");
  endtask
  task automatic test_delay(input logic half);
    int n;
    int lo;
    int hi;
    lo = half ? 12 : 24;
    hi = half ? 23 : 43;
    wr_reg(dbc_pkg::OFS_DB_CTRL, {half, 15'h0003});
    wr_reg(dbc_pkg::OFS_RISE_DLY, 16'h0004);
    wr_reg(dbc_pkg::OFS_FALL_DLY, 16'h0004);
    lvl_a <= 1'b0;
    repeat (60) @(posedge clk);
    lvl_a <= 1'b1;
    wait_out(1'b0, 1'b1, n);
    check_in(n, lo, hi);
    @(posedge clk);
    lvl_a <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check({out_a, out_b}, 2'h1);
    wait_out(1'b1, 1'b0, n);
    check_in(n + 2, lo, hi);
    $display("delay done");
  endtask
  task automatic test_chop(input logic [2:0] duty, input logic [2:0] div, input logic [3:0] w);
    int n;
    int hi;
    wr_reg(dbc_pkg::OFS_DB_CTRL, 16'h0000);
    wr_reg(dbc_pkg::OFS_CHOP, {5'h00, duty, div, w, 1'b1});
    @(posedge clk);
    lvl_a <= 1'b1;
    wait_out(1'b0, 1'b1, n);
    hi = 0;
    for (int i = 1; i < 8 * (w + 1); i++) begin
      @(posedge clk);
      #1 hi += int'(out_a === 1'b1);
    end
    check_in(hi, 8 * w + 7, 8 * w + 7);
    hi = 0;
    for (int i = 0; i < 64 * (div + 1); i++) begin
      @(posedge clk);
      #1 hi += int'(out_a === 1'b1);
    end
    n = 8 * (div + 1) * ((duty == 3'h7 ? 6 : duty) + 1);
    check_in(hi, n, n);
    @(posedge clk);
    lvl_a <= 1'b0;
    $display("chopper done");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    test_regs();
    test_bypass();
    test_modes();
    test_delay(1'b0);
    test_delay(1'b1);
    test_chop(3'h3, 3'h0, 4'h0);
    test_chop(3'h0, 3'h1, 4'h2);
    test_chop(3'h6, 3'h7, 4'hF);
    test_chop(3'h7, 3'h0, 4'h1);
    end_of_test();
  end
endmodule
`default_nettype wire
